// file: wdt_device.sv
// watchdog logical device behind an index/data i/o port pair
//
// Register access over APB was decided locally.
`include "wdt_cfg.svh"
`timescale 1ns/1ps
module wdt_device #(
  parameter int unsigned CYC_PER_UNIT = `WDT_SEC_PER_TICK * `REF_CLK_HZ
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // host i/o port bus
  wdt_port_if.dev PORT,
  // shared pin, low while timed out and routed
  output logic WATCHDOG_TIMEOUT_OUTPUT_N
);
  wdt_pkg::dev_state_t s_r;
  wdt_pkg::dev_state_t s_nxt;

  logic sec_tick;
  logic tick_clr;
  logic running;
  logic unit_tick;
  logic expire;
  logic load_cnt;
  logic sel_idx;
  logic sel_dat;
  logic wr_idx;
  logic wr_dat;
  logic rd_dat;

  localparam logic [5:0] LAST_SEC = 6'(`WDT_SEC_PER_MIN - 1);

  // device-specific registers only answer for the watchdog device
  function automatic logic wdt_selected(input logic [7:0] ldn);
    wdt_selected = (ldn == `WDT_LDN);
  endfunction

  function automatic logic [7:0] reg_read(input wdt_pkg::dev_state_t st);
    logic [7:0] v;
    v = 8'h00;
    if (st.index == `REG_LDN) begin
      v = st.ldn;
    end else if (st.index == `REG_PIN) begin
      v = st.pin_sel;
    end else if (wdt_selected(st.ldn)) begin
      if (st.index == `REG_ACT) begin
        v = st.act;
      end else if (st.index == `REG_MODE) begin
        v = st.mode;
      end else if (st.index == `REG_COUNT) begin
        v = st.count;
      end
    end
    reg_read = v;
  endfunction

  // address decode of the port pair
  assign sel_idx = (PORT.io_addr == `IO_INDEX_PORT);
  assign sel_dat = (PORT.io_addr == `IO_DATA_PORT);
  assign wr_idx = PORT.io_wr && sel_idx;
  assign wr_dat = PORT.io_wr && sel_dat;
  assign rd_dat = PORT.io_rd && sel_dat;

  // a zero count means stopped, never expired
  assign running = s_r.act[`ACT_EN_BIT] && (s_r.count != 8'h00);

  assign load_cnt = wr_dat && s_r.cfg_open && wdt_selected(s_r.ldn) &&
                    (s_r.index == `REG_COUNT);

  // restart the unit so a reload gets a full first unit
  assign tick_clr = load_cnt || !running;

  wdt_sec_ticker #(
    .CYC(CYC_PER_UNIT)
  ) u_ticker (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .clr(tick_clr),
    .tick(sec_tick)
  );

  // unit selection: seconds pass straight, minutes count 60 of them
  always_comb begin
    unit_tick = 1'b0;
    if (sec_tick) begin
      if (s_r.mode[`MODE_MIN_BIT]) begin
        unit_tick = (s_r.sub == LAST_SEC);
      end else begin
        unit_tick = 1'b1;
      end
    end
  end

  assign expire = running && unit_tick && (s_r.count == 8'h01);

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;

    // seconds within the current minute
    if (load_cnt || !running) begin
      s_nxt.sub = 6'h00;
    end else if (sec_tick && s_r.mode[`MODE_MIN_BIT]) begin
      if (s_r.sub == LAST_SEC) begin
        s_nxt.sub = 6'h00;
      end else begin
        s_nxt.sub = s_r.sub + 6'h01;
      end
    end

    // countdown in whole units
    if (running && unit_tick) begin
      s_nxt.count = s_r.count - 8'h01;
    end
    if (expire) begin
      s_nxt.flag = 1'b1;
    end

    // every index write and data port access is acknowledged, locked or not; index port reads are not
    if (wr_idx || wr_dat || rd_dat) begin
      s_nxt.ack = 1'b1;
    end

    // index port: keys while locked, index or lock key while open
    if (wr_idx) begin
      if (!s_r.cfg_open) begin
        if (s_r.key_seen && (PORT.io_wdata == `KEY_UNLOCK)) begin
          s_nxt.cfg_open = 1'b1;
          s_nxt.key_seen = 1'b0;
        end else begin
          s_nxt.key_seen = (PORT.io_wdata == `KEY_UNLOCK);
        end
      end else if (PORT.io_wdata == `KEY_LOCK) begin
        s_nxt.cfg_open = 1'b0;
      end else begin
        s_nxt.index = PORT.io_wdata;
      end
    end

    // a data access breaks a pending key pair
    if (wr_dat || rd_dat) begin
      s_nxt.key_seen = 1'b0;
    end

    // locked reads float high, as an idle bus would
    if (rd_dat) begin
      if (s_r.cfg_open) begin
        s_nxt.rdata = reg_read(s_r);
      end else begin
        s_nxt.rdata = `LOCKED_RDATA;
      end
    end

    // data port writes, ignored while locked
    if (wr_dat && s_r.cfg_open) begin
      if (s_r.index == `REG_LDN) begin
        s_nxt.ldn = PORT.io_wdata;
      end else if (s_r.index == `REG_PIN) begin
        s_nxt.pin_sel = PORT.io_wdata;
      end else if (wdt_selected(s_r.ldn)) begin
        if (s_r.index == `REG_ACT) begin
          s_nxt.act = PORT.io_wdata;
        end else if (s_r.index == `REG_MODE) begin
          s_nxt.mode = PORT.io_wdata;
        end
      end
    end

    // reload clears a standing timeout; an expiry in the same cycle wins
    if (load_cnt) begin
      s_nxt.count = PORT.io_wdata;
      s_nxt.flag = expire;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_r <= '0;
      s_r.pin_sel <= `PIN_SEL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PORT.io_rdata = s_r.rdata;
  assign PORT.io_ack = s_r.ack;

  // one flag, steered to interrupt or reset by the mode register
  assign PORT.wdt_irq = s_r.flag && !s_r.mode[`MODE_RST_BIT];
  assign PORT.wdt_rst = s_r.flag && s_r.mode[`MODE_RST_BIT];

  // pin stays high unless the timeout is routed onto it
  assign WATCHDOG_TIMEOUT_OUTPUT_N =
    !(s_r.flag && !s_r.pin_sel[`PIN_ROUTE_BIT]);
endmodule

// file: wdt_cfg.svh
// offsets, field positions, reset values and timing counts
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// clock and counting unit
`define REF_CLK_HZ 10000000
`define WDT_SEC_PER_TICK 1
`define WDT_SEC_PER_MIN 60

// i/o port pair on the host bus
`define IO_INDEX_PORT 16'h002e
`define IO_DATA_PORT 16'h002f

// key bytes written to the index port
`define KEY_UNLOCK 8'h87
`define KEY_LOCK 8'haa

// configuration register indices
`define REG_LDN 8'h07
`define REG_PIN 8'h2d
`define REG_ACT 8'h30
`define REG_MODE 8'hf5
`define REG_COUNT 8'hf6

// logical device number of the watchdog
`define WDT_LDN 8'h08

// field positions
`define PIN_ROUTE_BIT 0
`define ACT_EN_BIT 0
`define MODE_MIN_BIT 3
`define MODE_RST_BIT 4

// reset and fixed values
`define PIN_SEL_RST 8'h01
`define LOCKED_RDATA 8'hff

// host controller apb map
`define HOST_CMD 12'h000
`define HOST_STATUS 12'h004
`define HOST_INT_ST 12'h008
`define HOST_INT_MASK 12'h00c

// host command and status fields
`define CMD_PORT_BIT 8
`define CMD_READ_BIT 9
`define ST_BUSY_BIT 0
`define ST_RDATA_LSB 8
`define ST_IRQ_BIT 16
`define ST_RST_BIT 17
`define INT_DONE_BIT 0
`define INT_WDT_BIT 1

`endif

// file: wdt_pkg.sv
// types shared by the watchdog device end and the host controller
package wdt_pkg;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ticker_state_t;

  typedef struct packed {
    logic key_seen;
    logic cfg_open;
    logic [7:0] index;
    logic [7:0] ldn;
    logic [7:0] pin_sel;
    logic [7:0] act;
    logic [7:0] mode;
    logic [7:0] count;
    logic [5:0] sub;
    logic flag;
    logic [7:0] rdata;
    logic ack;
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE,
    H_STROBE,
    H_WAIT
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t state;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic [7:0] rdata;
    logic [1:0] int_st;
    logic [1:0] int_mask;
    logic alarm_prev;
  } host_state_t;

endpackage

// file: wdt_port_if.sv
// i/o port bus and alarm lines between host controller and watchdog
`timescale 1ns/1ps
interface wdt_port_if;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_ack;
  logic wdt_irq;
  logic wdt_rst;

  modport dev (
    input io_addr,
    input io_wr,
    input io_rd,
    input io_wdata,
    output io_rdata,
    output io_ack,
    output wdt_irq,
    output wdt_rst
  );

  modport host (
    output io_addr,
    output io_wr,
    output io_rd,
    output io_wdata,
    input io_rdata,
    input io_ack,
    input wdt_irq,
    input wdt_rst
  );
endinterface

// file: wdt_sec_ticker.sv
// one-cycle tick every CYC clocks, restartable
`include "wdt_cfg.svh"
`timescale 1ns/1ps
module wdt_sec_ticker #(
  parameter int unsigned CYC = `REF_CLK_HZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic clr,
  // tick out
  output logic tick
);
  wdt_pkg::ticker_state_t s_r;
  wdt_pkg::ticker_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (clr) begin
      s_nxt.cnt = 32'h00000000;
    end else if (s_r.cnt == 32'(CYC - 1)) begin
      s_nxt.cnt = 32'h00000000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// file: wdt_host.sv
// host controller: apb command registers driving the i/o port pair
`include "wdt_cfg.svh"
`timescale 1ns/1ps
module wdt_host (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // interrupt
  output logic IRQ,
  // link to the watchdog device
  wdt_port_if.host PORT
);
  wdt_pkg::host_state_t s_r;
  wdt_pkg::host_state_t s_nxt;

  logic acc;
  logic wr;
  logic mapped;
  logic alarm;
  logic [1:0] ev;
  logic [1:0] clr;

  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE;
  assign mapped = (PADDR == `HOST_CMD) || (PADDR == `HOST_STATUS) ||
                  (PADDR == `HOST_INT_ST) || (PADDR == `HOST_INT_MASK);
  assign alarm = PORT.wdt_irq || PORT.wdt_rst;

  always_comb begin
    s_nxt = s_r;
    ev = 2'b00;
    clr = 2'b00;
    s_nxt.alarm_prev = alarm;
    ev[`INT_WDT_BIT] = alarm && !s_r.alarm_prev;
    unique case (s_r.state)
      wdt_pkg::H_IDLE: begin
        // one port access per command; software orders index then data
        if (wr && (PADDR == `HOST_CMD)) begin
          s_nxt.addr = PWDATA[`CMD_PORT_BIT] ? `IO_DATA_PORT
                                              : `IO_INDEX_PORT;
          s_nxt.wdata = PWDATA[7:0];
          s_nxt.rd = PWDATA[`CMD_READ_BIT];
          s_nxt.state = wdt_pkg::H_STROBE;
        end
      end
      wdt_pkg::H_STROBE: begin
        s_nxt.state = wdt_pkg::H_WAIT;
      end
      wdt_pkg::H_WAIT: begin
        if (PORT.io_ack) begin
          if (s_r.rd) begin
            s_nxt.rdata = PORT.io_rdata;
          end
          ev[`INT_DONE_BIT] = 1'b1;
          s_nxt.state = wdt_pkg::H_IDLE;
        end
      end
      default: begin
        s_nxt.state = wdt_pkg::H_IDLE;
      end
    endcase
    if (wr && (PADDR == `HOST_INT_ST)) begin
      clr = PWDATA[1:0];
    end
    if (wr && (PADDR == `HOST_INT_MASK)) begin
      s_nxt.int_mask = PWDATA[1:0];
    end
    // a new event beats a clear in the same cycle
    s_nxt.int_st = (s_r.int_st & ~clr) | ev;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_r <= '0;
      s_r.addr <= `IO_INDEX_PORT;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    PRDATA = 32'h00000000;
    if (PADDR == `HOST_STATUS) begin
      PRDATA[`ST_BUSY_BIT] = (s_r.state != wdt_pkg::H_IDLE);
      PRDATA[`ST_RDATA_LSB +: 8] = s_r.rdata;
      PRDATA[`ST_IRQ_BIT] = PORT.wdt_irq;
      PRDATA[`ST_RST_BIT] = PORT.wdt_rst;
    end else if (PADDR == `HOST_INT_ST) begin
      PRDATA[1:0] = s_r.int_st;
    end else if (PADDR == `HOST_INT_MASK) begin
      PRDATA[1:0] = s_r.int_mask;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;
  assign IRQ = |(s_r.int_st & s_r.int_mask);

  assign PORT.io_addr = s_r.addr;
  assign PORT.io_wdata = s_r.wdata;
  assign PORT.io_wr = (s_r.state == wdt_pkg::H_STROBE) && !s_r.rd;
  assign PORT.io_rd = (s_r.state == wdt_pkg::H_STROBE) && s_r.rd;
endmodule

// file: wdt_properties.sv
// assertions on the i/o port link between host controller and watchdog
`timescale 1ns/1ps
module wdt_properties (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // port link
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_ack,
  input wire logic wdt_irq,
  input wire logic wdt_rst
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic idx_wr;
  logic dat_acc;
  logic acc;
  logic stb;
  assign idx_wr = io_wr && io_addr == 16'h002e;
  assign dat_acc = (io_wr || io_rd) && io_addr == 16'h002f;
  assign acc = idx_wr || dat_acc;
  assign stb = io_wr || io_rd;

  idx_ack_a: assert property (idx_wr |=> io_ack)
    else $error("index write not acknowledged");
  data_ack_a: assert property (dat_acc |=> io_ack)
    else $error("data access not acknowledged");
  ack_cause_a: assert property (io_ack |-> $past(acc))
    else $error("acknowledge without access");
  rdata_hold_a: assert property (!io_ack |-> $stable(io_rdata))
    else $error("read data moved without acknowledge");
  alarm_excl_a: assert property (!(wdt_irq && wdt_rst))
    else $error("interrupt and reset both raised");
  irq_hold_a: assert property (wdt_irq && !io_wr |=> wdt_irq)
    else $error("interrupt dropped without a write");
  rst_hold_a: assert property (wdt_rst && !io_wr |=> wdt_rst)
    else $error("reset dropped without a write");
  strobe_gap_a: assert property (stb |=> !stb [*2])
    else $error("strobes too close");
endmodule

// file: tb_top.sv
// bench: apb controller drives the watchdog over the port link
`include "wdt_cfg.svh"
`timescale 1ns/1ps
module tb_top;
  localparam int CYC = 10;
  logic clk;
  logic arst_n;
  logic psel;
  logic pen;
  logic pwr;
  logic [11:0] pa;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic irq;
  logic watchdog_timeout_output_n;
  logic [31:0] q;
  logic e;
  int n_errors;
  int checks_done;
  int n;
  // row: data port, read, byte, read byte expected
  localparam logic [17:0] ROWS [18] = '{18'h300ff, 18'h08700, 18'h08700,
    18'h02d00, 18'h30001, 18'h20000, 18'h30000, 18'h03000, 18'h30000,
    18'h00700, 18'h20800, 18'h03000, 18'h20100, 18'h30001, 18'h0f500,
    18'h20800, 18'h30008, 18'h20000};
  wdt_port_if port_if();
  wdt_host i_wdt_host (.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .IRQ(irq), .PORT(port_if.host));
  wdt_device #(.CYC_PER_UNIT(CYC)) i_wdt_device (.REF_CLK(clk),
    .ARST_N(arst_n), .PORT(port_if.dev), .WATCHDOG_TIMEOUT_OUTPUT_N(watchdog_timeout_output_n));
  wdt_properties i_wdt_properties (.REF_CLK(clk), .ARST_N(arst_n),
    .io_addr(port_if.io_addr), .io_wr(port_if.io_wr), .io_rd(port_if.io_rd),
    .io_wdata(port_if.io_wdata), .io_rdata(port_if.io_rdata),
    .io_ack(port_if.io_ack), .wdt_irq(port_if.wdt_irq),
    .wdt_rst(port_if.wdt_rst));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ready and read data taken at the rising edge that ends the access,
  // before that edge's register updates land
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      give_verdict();
    end
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // one port access, then poll busy; q holds the final status word
  task automatic op(input logic p, input logic r, input logic [7:0] d);
    int i;
    apb(1'b1, `HOST_CMD, {22'h0, r, p, d});
    for (i = 0; i < 20; i++) begin
      apb(1'b0, `HOST_STATUS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      give_verdict();
    end
  endtask

  task automatic set(input logic [7:0] r, input logic [7:0] v);
    op(1'b0, 1'b0, r);
    op(1'b1, 1'b0, v);
  endtask

  // n ends at lim + 1 when no alarm came
  task automatic wait_alarm(input int lim);
    for (n = 0; n <= lim; n++) begin
      @(negedge clk);
      if ((port_if.wdt_irq | port_if.wdt_rst) === 1'b1) break;
    end
  endtask

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    pa = 12'h000;
    pwd = 32'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, `HOST_STATUS, 32'h0);
    check(q, 32'h0);
    for (int k = 0; k < 18; k++) begin
      op(ROWS[k][17], ROWS[k][16], ROWS[k][15:8]);
      if (ROWS[k][16]) check(32'(q[15:8]), 32'(ROWS[k][7:0]));
    end
    set(`REG_COUNT, 8'h02);
    wait_alarm(4 * CYC);
    check(32'(n >= 2 * CYC - 3 && n <= 2 * CYC + 3), 32'h1);
    check(32'({watchdog_timeout_output_n, port_if.wdt_irq, port_if.wdt_rst}), 32'h2);
    apb(1'b0, `HOST_STATUS, 32'h0);
    check(32'(q[17:16]), 32'h1);
    apb(1'b0, `HOST_INT_ST, 32'h0);
    check(q, 32'h3);
    check(32'(irq), 32'h0);
    apb(1'b1, `HOST_INT_MASK, 32'h2);
    @(negedge clk);
    check(32'(irq), 32'h1);
    apb(1'b1, `HOST_INT_ST, 32'h3);
    @(negedge clk);
    check(32'(irq), 32'h0);
    // reset action, one second
    set(`REG_MODE, 8'h10);
    set(`REG_COUNT, 8'h01);
    check(32'(port_if.wdt_rst), 32'h0);
    wait_alarm(2 * CYC);
    check(32'(n >= CYC - 3 && n <= CYC + 3), 32'h1);
    check(32'({port_if.wdt_irq, port_if.wdt_rst}), 32'h1);
    set(`REG_MODE, 8'h08);
    set(`REG_COUNT, 8'h01);
    wait_alarm(70 * CYC);
    check(32'(n >= 59 * CYC && n <= 61 * CYC + 3), 32'h1);
    op(1'b1, 1'b0, 8'h00);
    wait_alarm(3 * CYC);
    check(32'(n), 32'(3 * CYC + 1));
    set(`REG_MODE, 8'h00);
    set(`REG_ACT, 8'h00);
    set(`REG_COUNT, 8'h01);
    wait_alarm(3 * CYC);
    check(32'(n), 32'(3 * CYC + 1));
    set(`REG_ACT, 8'h01);
    wait_alarm(2 * CYC);
    check(32'(n >= CYC - 3 && n <= CYC + 3), 32'h1);
    // reset in mid-run with the alarm raised
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    check(32'({watchdog_timeout_output_n, irq, port_if.wdt_irq}), 32'h4);
    @(posedge clk);
    arst_n <= 1'b1;
    op(1'b0, 1'b0, `KEY_UNLOCK);
    op(1'b1, 1'b1, 8'h00);
    check(32'(q[15:8]), 32'hff);
    op(1'b0, 1'b0, `KEY_UNLOCK);
    op(1'b1, 1'b1, 8'h00);
    check(32'(q[15:8]), 32'hff);
    op(1'b0, 1'b0, `KEY_UNLOCK);
    op(1'b0, 1'b0, `KEY_UNLOCK);
    op(1'b1, 1'b1, 8'h00);
    check(32'(q[15:8]), 32'h0);
    op(1'b0, 1'b0, `KEY_LOCK);
    op(1'b1, 1'b1, 8'h00);
    check(32'(q[15:8]), 32'hff);
    apb(1'b0, 12'h010, 32'h0);
    check({q[30:0], e}, 32'h1);
    give_verdict();
  end
endmodule
